// >>> hw/srb_pkg.sv
// Purpose: Shared constants and types for the refresh, mode and burst ROM controller
// Assumes: 32-bit AXI4-Lite register bus, one 20 MHz clock
// Notes:   Register offsets are byte addresses of aligned words
package srb_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0]  SRB_OFS_MCR    = 8'h00;
  localparam logic [7:0]  SRB_OFS_RCNT   = 8'h04;
  localparam logic [7:0]  SRB_OFS_RCON   = 8'h08;
  localparam logic [7:0]  SRB_OFS_BCR    = 8'h0c;
  localparam logic [7:0]  SRB_OFS_STAT   = 8'h10;
  // memory_control_reg fields
  localparam int          SRB_MCR_RFEN   = 0;
  localparam int          SRB_MCR_REFRESH_MODE_SELECT  = 1;
  localparam int          SRB_MCR_TPC    = 2;
  localparam int          SRB_MCR_TRAS   = 5;
  localparam logic [7:0]  SRB_MCR_RST    = 8'h00;
  localparam logic [7:0]  SRB_RCNT_RST   = 8'h00;
  localparam logic [7:0]  SRB_RCON_RST   = 8'h00;
  // bus_control_reg_one fields, per area 0, 5, 6
  localparam int          SRB_BCR_CNT    = 0;
  localparam int          SRB_BCR_WID    = 6;
  localparam int          SRB_BCR_WAIT   = 12;
  localparam logic [17:0] SRB_BCR_RST    = 18'h00000;
  // Mode register windows, upper 20 address bits
  localparam logic [19:0] SRB_WIN_AREA2  = 20'hffffd;
  localparam logic [19:0] SRB_WIN_AREA3  = 20'hffffe;
  localparam logic [1:0]  SRB_RESP_OK    = 2'h0;
  localparam logic [1:0]  SRB_RESP_ERR   = 2'h2;
  localparam int          SRB_PRESCALE   = 4;

  // SDRAM commands as {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    SRB_CMD_MRS  = 3'b000,
    SRB_CMD_REF  = 3'b001,
    SRB_CMD_PALL = 3'b010,
    SRB_CMD_NOP  = 3'b111
  } srb_cmd_t;

  typedef enum logic [3:0] {
    SRB_ST_IDLE  = 4'b0000,
    SRB_ST_ROM   = 4'b0001,
    SRB_ST_MPRE  = 4'b0010,
    SRB_ST_MPW   = 4'b0011,
    SRB_ST_MRS   = 4'b0100,
    SRB_ST_RPRE  = 4'b0101,
    SRB_ST_RPW   = 4'b0110,
    SRB_ST_REF   = 4'b0111,
    SRB_ST_RREC  = 4'b1000,
    SRB_ST_SPRE  = 4'b1001,
    SRB_ST_SPW   = 4'b1010,
    SRB_ST_SENT  = 4'b1011,
    SRB_ST_SELF  = 4'b1100,
    SRB_ST_SEXIT = 4'b1101
  } srb_state_t;
endpackage : srb_pkg

// >>> hw/srb_ctrl.sv
// Purpose: SDRAM refresh, self-refresh, mode register write and burst ROM sequencing
// Assumes: Requester holds i_req until o_ack; i_bus_released and i_other_irq are synchronous
// Notes:   SDRAM and ROM pins are registered, one cycle behind the state that drives them
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Both refresh bits set starts self-refresh.
// - Self-refresh holds CKE low and blocks every SDRAM access.
// - Clearing mode select ends self-refresh, then precharge wait without commands.
// - Auto-refresh resumes after exit when enable set and mode clear.
// - Self-refresh survives standby entry and non power-on recovery.
// - Power-on reset restores registers and cancels self-refresh.
// - Self-refresh holds in normal, sleep, standby and manual reset.
// - Refresh waits for bus cycle end and for bus regain.
// - New match while pending drops old request; one remains.
// - Interrupt out low on request, high at refresh start unless others.
// - Byte write to area mode window loads offset into mode register.
// - Mode write issues precharge-all then mode register write.
// - Mode write address carries burst mode, latency, wrap, length.
// - Non-zero burst setting makes area 0, 5, 6 burst ROM.
// - Burst lengths 4/8/16 for 8-bit, 4/8 16-bit, 4 32-bit.
// - Wait sampled in first access only with waits, always later.
// - Zero-wait burst still takes two cycles per later access.
// - Wait ignored for 16-byte DMA and cache write-back accesses.
// - Counter matching constant raises request and restarts counter.
// - Enable set with mode clear selects periodic auto-refresh.
module srb_ctrl
  import srb_pkg::*;
#(
  parameter int PRESCALE = SRB_PRESCALE
) (
  // Clock and power-on reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // AXI4-Lite slave
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // Manual reset and wait pins
  input  wire logic        i_mrst_n,
  input  wire logic        i_wait_n,
  // Arbitration and interrupt context
  input  wire logic        i_bus_released,
  input  wire logic        i_other_irq,
  // Access requests
  input  wire logic        i_req,
  input  wire logic        i_req_wr,
  input  wire logic        i_req_byte,
  input  wire logic [31:0] i_req_addr,
  input  wire logic [2:0]  i_req_area,
  input  wire logic        i_wait_ignore,
  output logic             o_ack,
  output logic             o_beat,
  // Burst ROM pins
  output logic [2:0]       o_rom_cs_n,
  output logic [25:0]      o_rom_addr,
  // SDRAM pins
  output logic             o_cke,
  output logic [1:0]       o_sd_cs_n,
  output logic             o_sd_ras_n,
  output logic             o_sd_cas_n,
  output logic             o_sd_we_n,
  output logic [15:0]      o_sd_addr,
  // Refresh request to bus masters
  output logic             o_irq_out_n
);
  ////////////////////////////////////////////////////////////////////////////
  srb_state_t  state_ff;
  srb_state_t  nxt_state;
  logic [7:0]  mcr_ff;
  logic [7:0]  rcnt_ff;
  logic [7:0]  rcon_ff;
  logic [17:0] bcr_ff;
  logic        pend_ff;
  logic        nxt_pend;
  logic [3:0]  wcnt_ff;
  logic [1:0]  mrst_meta_ff;
  logic [1:0]  wait_meta_ff;
  logic [7:0]  pre_ff;
  logic        tick;
  logic        match;
  logic        refr_start;
  logic        rfen;
  logic        refresh_mode_select;
  logic [3:0]  tpc_cyc;
  logic [3:0]  rec_cyc;
  // Register bus
  logic        aw_have_ff;
  logic        w_have_ff;
  logic [7:0]  waddr_ff;
  logic [31:0] wdat_ff;
  logic [3:0]  wstb_ff;
  logic        wr_en;
  logic [31:0] wmask;
  // Access
  logic [11:0] mode_x_ff;
  logic [1:0]  mode_cs_ff;
  logic [4:0]  left_ff;
  logic [2:0]  step_ff;
  logic [1:0]  lim_ff;
  logic [1:0]  cyc_ff;
  logic        first_ff;
  logic [1:0]  waits_ff;
  logic        wign_ff;
  logic [2:0]  rcs_ff;
  logic [25:0] raddr_ff;
  logic        rom_done;
  logic        rom_next;
  logic        take_req;
  logic        is_mode;
  logic [1:0]  a_cnt;
  logic [1:0]  a_wid;
  logic [1:0]  a_wait;
  logic [2:0]  a_cs;
  logic        mrst;

  assign rfen    = mcr_ff[SRB_MCR_RFEN];
  assign refresh_mode_select   = mcr_ff[SRB_MCR_REFRESH_MODE_SELECT];
  assign tpc_cyc = {1'b0, mcr_ff[SRB_MCR_TPC +: 3]} + 4'h1;
  assign rec_cyc = tpc_cyc + {1'b0, mcr_ff[SRB_MCR_TRAS +: 3]};
  assign mrst    = ~mrst_meta_ff[1];

  function automatic logic [4:0] srb_len(input logic [1:0] cnt, input logic [1:0] wid);
    logic [4:0] len;
    len = 5'h01;
    case (cnt)
      2'h1:    len = 5'h04;
      2'h2:    len = (wid == 2'h2) ? 5'h04 : 5'h08;
      2'h3:    len = (wid == 2'h2) ? 5'h04 : ((wid == 2'h1) ? 5'h08 : 5'h10);
      default: len = 5'h01;
    endcase
    return len;
  endfunction : srb_len

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mrst_meta_ff <= 2'h3;
      wait_meta_ff <= 2'h3;
    end else begin
      mrst_meta_ff <= {mrst_meta_ff[0], i_mrst_n};
      wait_meta_ff <= {wait_meta_ff[0], i_wait_n};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel, address and data in either order
  assign wr_en = aw_have_ff & w_have_ff & ~o_bvalid;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstb_ff[b]}};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      o_awready  <= 1'b1;
      o_wready   <= 1'b1;
      waddr_ff   <= 8'h00;
      wdat_ff    <= 32'h00000000;
      wstb_ff    <= 4'h0;
      o_bvalid   <= 1'b0;
      o_bresp    <= SRB_RESP_OK;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_have_ff <= 1'b1;
        o_awready  <= 1'b0;
        waddr_ff   <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_have_ff <= 1'b1;
        o_wready  <= 1'b0;
        wdat_ff   <= i_wdata;
        wstb_ff   <= i_wstrb;
      end
      if (wr_en) begin
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
        o_bvalid   <= 1'b1;
        o_bresp    <= (waddr_ff <= SRB_OFS_BCR && waddr_ff[1:0] == 2'h0) ?
                      SRB_RESP_OK : SRB_RESP_ERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // Read channel, one cycle to answer
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= SRB_RESP_OK;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= SRB_RESP_OK;
      case (i_araddr)
        SRB_OFS_MCR:  o_rdata <= {24'h000000, mcr_ff};
        SRB_OFS_RCNT: o_rdata <= {24'h000000, rcnt_ff};
        SRB_OFS_RCON: o_rdata <= {24'h000000, rcon_ff};
        SRB_OFS_BCR:  o_rdata <= {14'h0000, bcr_ff};
        SRB_OFS_STAT: o_rdata <= {26'h0000000, o_cke, pend_ff, state_ff};
        default: begin
          o_rdata <= 32'h00000000;
          o_rresp <= SRB_RESP_ERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; only a power-on reset clears them
  // Power-on clears
  // No standby or manual reset path touches these
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mcr_ff  <= SRB_MCR_RST;
      rcon_ff <= SRB_RCON_RST;
      bcr_ff  <= SRB_BCR_RST;
    end else if (wr_en) begin
      case (waddr_ff)
        SRB_OFS_MCR:  mcr_ff  <= (mcr_ff & ~wmask[7:0]) | (wdat_ff[7:0] & wmask[7:0]);
        SRB_OFS_RCON: rcon_ff <= (rcon_ff & ~wmask[7:0]) | (wdat_ff[7:0] & wmask[7:0]);
        SRB_OFS_BCR:  bcr_ff  <= (bcr_ff & ~wmask[17:0]) | (wdat_ff[17:0] & wmask[17:0]);
        default:      mcr_ff  <= mcr_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh interval counter on a prescaled tick
  assign tick  = (pre_ff == 8'(PRESCALE - 1));
  assign match = tick & rfen & ~refresh_mode_select & (rcnt_ff == rcon_ff);
  assign refr_start = (state_ff == SRB_ST_RPRE);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_ff  <= 8'h00;
      rcnt_ff <= SRB_RCNT_RST;
    end else begin
      pre_ff <= tick ? 8'h00 : pre_ff + 8'h01;
      if (wr_en && waddr_ff == SRB_OFS_RCNT) begin
        rcnt_ff <= (rcnt_ff & ~wmask[7:0]) | (wdat_ff[7:0] & wmask[7:0]);
      end else if (match) begin
        rcnt_ff <= 8'h00;
      end else if (tick && rfen && !refresh_mode_select) begin
        rcnt_ff <= rcnt_ff + 8'h01;
      end
    end
  end

  // Single pending flag; a new match just replaces it
  // Set wins over the clear at refresh start
  assign nxt_pend = match | (pend_ff & ~refr_start);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_ff     <= 1'b0;
      o_irq_out_n <= 1'b1;
    end else begin
      pend_ff     <= nxt_pend;
      o_irq_out_n <= ~(nxt_pend | i_other_irq);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Area attribute decode
  always_comb begin
    a_cnt  = 2'h0;
    a_wid  = 2'h0;
    a_wait = 2'h0;
    a_cs   = 3'b111;
    case (i_req_area)
      3'h0: begin
        a_cnt = bcr_ff[SRB_BCR_CNT +: 2];
        a_wid = bcr_ff[SRB_BCR_WID +: 2];
        a_wait = bcr_ff[SRB_BCR_WAIT +: 2];
        a_cs = 3'b110;
      end
      3'h5: begin
        a_cnt = bcr_ff[SRB_BCR_CNT + 2 +: 2];
        a_wid = bcr_ff[SRB_BCR_WID + 2 +: 2];
        a_wait = bcr_ff[SRB_BCR_WAIT + 2 +: 2];
        a_cs = 3'b101;
      end
      3'h6: begin
        a_cnt = bcr_ff[SRB_BCR_CNT + 4 +: 2];
        a_wid = bcr_ff[SRB_BCR_WID + 4 +: 2];
        a_wait = bcr_ff[SRB_BCR_WAIT + 4 +: 2];
        a_cs = 3'b011;
      end
      default: a_cs = 3'b111;
    endcase
  end

  assign is_mode  = i_req_wr & i_req_byte &
                    (i_req_addr[31:12] == SRB_WIN_AREA2 ||
                     i_req_addr[31:12] == SRB_WIN_AREA3);
  // Ack flop guards against retaking the request just answered
  assign take_req = i_req & ~o_ack;
  assign rom_done = (cyc_ff == lim_ff) &&
                    (wign_ff || (first_ff && waits_ff == 2'h0) || wait_meta_ff[1]);
  assign rom_next = rom_done & (left_ff != 5'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SRB_ST_IDLE: begin
        if (rfen && refresh_mode_select) begin
          nxt_state = SRB_ST_SPRE;
        end else if (pend_ff && !i_bus_released) begin
          nxt_state = SRB_ST_RPRE;
        end else if (take_req && !mrst) begin
          nxt_state = is_mode ? SRB_ST_MPRE : SRB_ST_ROM;
        end
      end
      // Burst runs to its end before any refresh
      SRB_ST_ROM:   nxt_state = (mrst || (rom_done && !rom_next)) ? SRB_ST_IDLE : SRB_ST_ROM;
      SRB_ST_MPRE:  nxt_state = SRB_ST_MPW;
      SRB_ST_MPW:   nxt_state = (wcnt_ff <= 4'h1) ? SRB_ST_MRS : SRB_ST_MPW;
      SRB_ST_MRS:   nxt_state = SRB_ST_IDLE;
      SRB_ST_RPRE:  nxt_state = SRB_ST_RPW;
      SRB_ST_RPW:   nxt_state = (wcnt_ff <= 4'h1) ? SRB_ST_REF : SRB_ST_RPW;
      SRB_ST_REF:   nxt_state = SRB_ST_RREC;
      SRB_ST_RREC:  nxt_state = (wcnt_ff <= 4'h1) ? SRB_ST_IDLE : SRB_ST_RREC;
      SRB_ST_SPRE:  nxt_state = SRB_ST_SPW;
      SRB_ST_SPW:   nxt_state = (wcnt_ff <= 4'h1) ? SRB_ST_SENT : SRB_ST_SPW;
      SRB_ST_SENT:  nxt_state = SRB_ST_SELF;
      // Only the mode bit ends it, manual reset included
      SRB_ST_SELF:  nxt_state = refresh_mode_select ? SRB_ST_SELF : SRB_ST_SEXIT;
      // Back to idle where pending refreshes run
      SRB_ST_SEXIT: nxt_state = (wcnt_ff <= 4'h1) ? SRB_ST_IDLE : SRB_ST_SEXIT;
      default:      nxt_state = SRB_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= SRB_ST_IDLE;
      wcnt_ff  <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        case (nxt_state)
          SRB_ST_MPW, SRB_ST_RPW, SRB_ST_SPW, SRB_ST_SEXIT: wcnt_ff <= tpc_cyc;
          SRB_ST_RREC: wcnt_ff <= rec_cyc;
          default:     wcnt_ff <= 4'h0;
        endcase
      end else if (wcnt_ff != 4'h0) begin
        wcnt_ff <= wcnt_ff - 4'h1;
      end
    end
  end

  // Burst ROM access tracking
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left_ff    <= 5'h00;
      step_ff    <= 3'h1;
      lim_ff     <= 2'h0;
      cyc_ff     <= 2'h0;
      first_ff   <= 1'b0;
      waits_ff   <= 2'h0;
      wign_ff    <= 1'b0;
      rcs_ff     <= 3'b111;
      raddr_ff   <= 26'h0000000;
      mode_x_ff  <= 12'h000;
      mode_cs_ff <= 2'h3;
    end else if (state_ff == SRB_ST_IDLE && nxt_state == SRB_ST_ROM) begin
      left_ff  <= srb_len(a_cnt, a_wid) - 5'h01;
      step_ff  <= (a_wid == 2'h2) ? 3'h4 : ((a_wid == 2'h1) ? 3'h2 : 3'h1);
      lim_ff   <= a_wait;
      cyc_ff   <= 2'h0;
      first_ff <= 1'b1;
      waits_ff <= a_wait;
      wign_ff  <= i_wait_ignore;
      rcs_ff   <= a_cs;
      raddr_ff <= i_req_addr[25:0];
    end else if (state_ff == SRB_ST_IDLE && nxt_state == SRB_ST_MPRE) begin
      mode_x_ff  <= i_req_addr[11:0];
      mode_cs_ff <= (i_req_addr[31:12] == SRB_WIN_AREA2) ? 2'b10 : 2'b01;
    end else if (state_ff == SRB_ST_ROM) begin
      if (mrst || (rom_done && !rom_next)) begin
        rcs_ff <= 3'b111;
      end else if (rom_next) begin
        left_ff  <= left_ff - 5'h01;
        raddr_ff <= raddr_ff + {23'h000000, step_ff};
        cyc_ff   <= 2'h0;
        first_ff <= 1'b0;
        lim_ff   <= 2'h1;
      end else if (cyc_ff != lim_ff) begin
        cyc_ff <= cyc_ff + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered pins
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cke      <= 1'b1;
      o_sd_cs_n  <= 2'h3;
      {o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= SRB_CMD_NOP;
      o_sd_addr  <= 16'h0000;
      o_rom_cs_n <= 3'b111;
      o_rom_addr <= 26'h0000000;
      o_ack      <= 1'b0;
      o_beat     <= 1'b0;
    end else begin
      o_sd_cs_n  <= 2'h3;
      {o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= SRB_CMD_NOP;
      o_sd_addr  <= 16'h0000;
      o_rom_cs_n <= (state_ff == SRB_ST_ROM) ? rcs_ff : 3'b111;
      o_rom_addr <= raddr_ff;
      o_beat     <= (state_ff == SRB_ST_ROM) && rom_done;
      o_ack      <= (state_ff == SRB_ST_MRS) ||
                    ((state_ff == SRB_ST_ROM) && (mrst || (rom_done && !rom_next)));
      // Low through self-refresh; raised on exit
      o_cke      <= !(state_ff == SRB_ST_SENT || state_ff == SRB_ST_SELF);
      case (state_ff)
        SRB_ST_MPRE, SRB_ST_RPRE, SRB_ST_SPRE: begin
          o_sd_cs_n <= (state_ff == SRB_ST_MPRE) ? mode_cs_ff : 2'h0;
          {o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= SRB_CMD_PALL;
          o_sd_addr <= 16'h0400;
        end
        SRB_ST_MRS: begin
          o_sd_cs_n <= mode_cs_ff;
          {o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= SRB_CMD_MRS;
          o_sd_addr <= {4'h0, mode_x_ff};
        end
        SRB_ST_REF, SRB_ST_SENT: begin
          o_sd_cs_n <= 2'h0;
          {o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= SRB_CMD_REF;
        end
        default: o_sd_cs_n <= 2'h3;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  self_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_ff == SRB_ST_IDLE && rfen && refresh_mode_select) |=> state_ff == SRB_ST_SPRE)
    else $error("self-refresh not entered");
  self_cke_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_ff == SRB_ST_SELF) |=> (!o_cke && o_sd_cs_n == 2'h3))
    else $error("CKE high or command during self-refresh");
  exit_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_ff == SRB_ST_SELF && !refresh_mode_select) |=> state_ff == SRB_ST_SEXIT ##1
      (o_cke && o_sd_cs_n == 2'h3))
    else $error("self-refresh exit not quiet");
  match_req_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    match |=> (pend_ff && rcnt_ff == 8'h00))
    else $error("counter match did not raise request");
  irq_low_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(pend_ff) |-> !o_irq_out_n)
    else $error("interrupt out not low on request");
  defer_bus_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_ff == SRB_ST_IDLE && i_bus_released && !(rfen && refresh_mode_select)) |=>
      state_ff != SRB_ST_RPRE)
    else $error("refresh ran while bus released");
  mode_seq_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_ff == SRB_ST_MRS) |=> ({o_sd_ras_n, o_sd_cas_n, o_sd_we_n} == SRB_CMD_MRS &&
      o_sd_addr[11:0] == $past(mode_x_ff)))
    else $error("mode write command wrong");
  burst_cs_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_ff == SRB_ST_ROM && rom_next && !mrst) |=> ##1 o_rom_cs_n == $past(rcs_ff, 2))
    else $error("chip select dropped inside burst");
  two_cycle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_beat && state_ff == SRB_ST_ROM) |=> !o_beat)
    else $error("later burst access shorter than two cycles");
  cov_self_c: cover property (@(posedge i_mclk) state_ff == SRB_ST_SELF ##1
    state_ff == SRB_ST_SEXIT);
  cov_ref_c: cover property (@(posedge i_mclk) state_ff == SRB_ST_REF);
  cov_mode_c: cover property (@(posedge i_mclk) state_ff == SRB_ST_MRS);
  cov_burst_c: cover property (@(posedge i_mclk) o_beat ##2 o_beat ##2 o_beat);
endmodule : srb_ctrl

// >>> verif/srb_far.sv
// Purpose: Far side model, bus arbiter and slow burst ROM
// Assumes: Samples controller pins on the rising edge
// Notes:   Wait stretches every other cycle so ROM accesses that sample it can be slowed
`timescale 1ns/1ps
module srb_far (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // Controller pins
  input  wire logic       i_hold,
  input  wire logic       i_irq_n,
  input  wire logic [2:0] i_cs_n,
  // Back to controller
  output logic            o_wait_n,
  output logic            o_released
);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) o_released <= 1'b0;
    else o_released <= i_hold & i_irq_n;
  end
  // Extension toggles only while a ROM is selected
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) o_wait_n <= 1'b1;
    else o_wait_n <= (&i_cs_n) | ~o_wait_n;
  end
endmodule : srb_far

// >>> verif/tb.sv
// Purpose: Self-checking bench for the refresh, mode and ROM controller
// Assumes: PRESCALE 1 so refresh matches come fast
// Notes:   Reads and mode writes are queued and checked by a monitor
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb
  import srb_pkg::*;
;
  logic        i_mclk = 1'b0, i_rst_n = 1'b0, aw = 1'b0, w = 1'b0, ar = 1'b0, rq = 1'b0;
  logic        rw = 1'b0, hold = 1'b0, mr_n = 1'b1, wt_n, rel, awr, wrd, bv, arr, rv;
  logic        ack, beat, cke, irq_n, ras, cas, we, wi = 1'b0, oi = 1'b0;
  logic [1:0]  rresp, sdcs;
  logic [2:0]  area = 3'h0, cs_n, c;
  logic [7:0]  ad = 8'h00;
  logic [11:0] x;
  logic [15:0] sa;
  logic [25:0] rma;
  logic [31:0] wd = 32'h0, ra = 32'h0, rdata, v, sd = 32'ha3b1;
  logic [33:0] q[$];
  int          checked = 0, n_fail = 0, k, i, nb;
  always #25 i_mclk = ~i_mclk;
  srb_ctrl #(.PRESCALE(1)) srb_ctrl_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_awvalid(aw), .o_awready(awr), .i_awaddr(ad), .i_wvalid(w), .o_wready(wrd),
    .i_wdata(wd), .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(1'b1), .o_bresp(),
    .i_arvalid(ar), .o_arready(arr), .i_araddr(ad), .o_rvalid(rv), .i_rready(1'b1),
    .o_rdata(rdata), .o_rresp(rresp), .i_mrst_n(mr_n), .i_wait_n(wt_n),
    .i_bus_released(rel), .i_other_irq(oi), .i_req(rq), .i_req_wr(rw),
    .i_req_byte(rw), .i_req_addr(ra), .i_req_area(area), .i_wait_ignore(wi),
    .o_ack(ack), .o_beat(beat), .o_rom_cs_n(cs_n), .o_rom_addr(rma), .o_cke(cke),
    .o_sd_cs_n(sdcs), .o_sd_ras_n(ras), .o_sd_cas_n(cas), .o_sd_we_n(we), .o_sd_addr(sa),
    .o_irq_out_n(irq_n));
  srb_far srb_far_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hold(hold),
    .i_irq_n(irq_n), .i_cs_n(cs_n), .o_wait_n(wt_n), .o_released(rel));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic tmo();
    n_fail++;
    summarize();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aw <= 1'b1;
    w <= 1'b1;
    ad <= a;
    wd <= d;
    for (k = 0; k < 50; k++) begin
      @(negedge i_mclk);
      c = {awr, wrd, bv};
      @(posedge i_mclk);
      if (c[2]) aw <= 1'b0;
      if (c[1]) w <= 1'b0;
      if (c[0]) break;
    end
    if (k == 50) tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    ar <= 1'b1;
    ad <= a;
    for (k = 0; k < 50; k++) begin
      @(negedge i_mclk);
      c = {arr, 1'b0, rv};
      @(posedge i_mclk);
      if (c[2]) ar <= 1'b0;
      if (c[0]) break;
    end
    if (k == 50) tmo();
  endtask : rd
  task automatic acc(input logic wr_n, input logic [31:0] a, input logic [2:0] ar_n,
      input int st);
    rq <= 1'b1;
    rw <= wr_n;
    ra <= a;
    area <= ar_n;
    nb = 0;
    for (k = 0; k < 300 && !ack; k++) begin
      @(negedge i_mclk);
      if (beat) `CHK("rom addr", a[25:0] + 26'(nb * st), rma)
      nb += int'(beat);
    end
    @(posedge i_mclk);
    rq <= 1'b0;
    @(posedge i_mclk);
    if (k == 300) tmo();
  endtask : acc
  task automatic rf();
    for (k = 0; k < 300 && irq_n; k++) @(negedge i_mclk);
    `CHK("irq low", 1'b0, irq_n)
    for (k = 0; k < 300 && !irq_n; k++) @(negedge i_mclk);
    `CHK("irq high", 1'b1, irq_n)
    @(posedge i_mclk);
  endtask : rf
  always @(negedge i_mclk) begin
    if (rv) `CHK("read", q.pop_front(), {rresp, rdata})
    if ({ras, cas, we} === SRB_CMD_MRS && cke)
      `CHK("mode", q.pop_front(), {16'h0, sdcs, sa})
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    rd(SRB_OFS_MCR, {SRB_RESP_OK, 32'h0});
    rd(8'h40, {SRB_RESP_ERR, 32'h0});
    v = 32'($random(sd)) & 32'hff;
    wr(SRB_OFS_RCON, v);
    rd(SRB_OFS_RCON, {SRB_RESP_OK, v});
    // Dummy auto-refresh cycles ahead of the mode writes
    wr(SRB_OFS_RCON, 32'h2);
    wr(SRB_OFS_MCR, 32'h1);
    repeat (8) rf();
    wr(SRB_OFS_MCR, 32'h0);
    // Every latency offset in both windows
    for (i = 0; i < 6; i++) begin
      x = 12'h840 + 12'(i % 3) * 12'h040;
      q.push_back({16'h0, i < 3 ? 2'b10 : 2'b01, 4'h0, x});
      acc(1'b1, {i < 3 ? SRB_WIN_AREA2 : SRB_WIN_AREA3, x}, i < 3 ? 3'h2 : 3'h3, 1);
    end
    wr(SRB_OFS_BCR, 32'h81);
    acc(1'b0, 32'h100, 3'h0, 4);
    `CHK("beats", 4, nb)
    // Area 5, 8-bit, one wait, wait pin ignored: two cycles per access
    wr(SRB_OFS_BCR, 32'h400c);
    wi <= 1'b1;
    acc(1'b0, 32'h200, 3'h5, 1);
    `CHK("beats", 16, nb)
    `CHK("burst cycles", 34, k)
    wi <= 1'b0;
    wr(SRB_OFS_RCON, 32'h2);
    hold <= 1'b1;
    wr(SRB_OFS_MCR, 32'h1);
    rf();
    wr(SRB_OFS_MCR, 32'h0);
    wr(SRB_OFS_RCNT, 32'h0);
    wr(SRB_OFS_MCR, 32'h3);
    mr_n <= 1'b0;
    repeat (30) @(negedge i_mclk);
    `CHK("cke self", 1'b0, cke)
    @(posedge i_mclk);
    mr_n <= 1'b1;
    wr(SRB_OFS_RCNT, 32'h1);
    wr(SRB_OFS_MCR, 32'h1);
    repeat (2) @(negedge i_mclk);
    `CHK("cke exit", 1'b1, cke)
    rf();
    wr(SRB_OFS_MCR, 32'h3);
    repeat (30) @(negedge i_mclk);
    `CHK("cke held", 1'b0, cke)
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(negedge i_mclk);
    `CHK("cke reset", 1'b1, cke)
    @(posedge i_mclk);
    // Other request keeps the line low with nothing pending
    oi <= 1'b1;
    repeat (2) @(negedge i_mclk);
    `CHK("irq other", 1'b0, irq_n)
    @(posedge i_mclk);
    oi <= 1'b0;
    rd(SRB_OFS_MCR, {SRB_RESP_OK, 32'h0});
    summarize();
  end
endmodule : tb
